// File: pkg/pdcs_pkg.sv
// Constants for the device control and status register pair.
// Assumes a configuration-access port on the core clock with byte enables.
package pdcs_pkg;

	// ==========================================
	// Register offsets
	localparam logic [11:0] PDCS_DEV_CTRL_OFS = 12'h078;
	localparam logic [11:0] PDCS_DEV_STAT_OFS = 12'h07A;
	localparam logic [11:0] PDCS_DWORD_MASK   = 12'hFFC;

	// ==========================================
	// Control and status field positions
	localparam int PDCS_FRT_BIT    = 15;
	localparam int PDCS_RRS_LO     = 12;
	localparam int PDCS_NS_BIT     = 11;
	localparam int PDCS_APPM_BIT   = 10;
	localparam int PDCS_PFE_BIT    = 9;
	localparam int PDCS_STAT_TRANSACTIONS_OUTSTANDING  = 5;
	localparam int PDCS_STAT_APD   = 4;
	localparam int PDCS_RRS_HI     = 14;
	localparam int PDCS_EXTENDED_TAG_ENABLE_BIT   = 8;
	localparam int PDCS_MPS_HI     = 7;
	localparam int PDCS_MPS_LO     = 5;
	localparam int PDCS_ERO_BIT    = 4;
	localparam int PDCS_ERR_HI     = 3;
	localparam int PDCS_BE_CTRL_HI = 1;

	// ==========================================
	// Reset values and masks
	localparam logic [15:0] PDCS_CTRL_RESET  = 16'h2810;
	localparam logic [15:0] PDCS_CTRL_RW     = 16'h7DFF;
	localparam logic [15:0] PDCS_CTRL_APPM   = 16'h0400;
	localparam logic [3:0]  PDCS_ERR_RESET   = 4'h0;
	localparam logic [2:0]  PDCS_RRS_MAX     = 3'h5;
	localparam logic [2:0]  PDCS_RRS_128B    = 3'h0;
	localparam logic [12:0] PDCS_RRS_BASE    = 13'h0080;
	localparam logic [2:0]  PDCS_RRS_RESET   = 3'h2;
	localparam logic [12:0] PDCS_RRS_RST_B   = 13'h0200;
	localparam logic [9:0]  PDCS_STAT_RSVD   = 10'h000;
	localparam logic [31:0] PDCS_RDATA_IDLE  = 32'h0000_0000;

endpackage

// File: rtl/pdcs_regs.sv
// Device control and device status registers of the PCIe capability.
// Assumes configuration accesses arrive as one-cycle dword strobes on the core clock.
`timescale 1ns/1ps
`default_nettype none
module pdcs_regs
	import pdcs_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        rstn_in,
	input  wire logic        global_rstn_in,
	input  wire logic        cfg_wr_in,
	input  wire logic        cfg_rd_in,
	input  wire logic [11:0] cfg_addr_in,
	input  wire logic [3:0]  cfg_be_in,
	input  wire logic [31:0] cfg_wdata_in,
	output logic      [31:0] cfg_rdata_out,
	input  wire logic        aux_power_detect_pin_in,
	input  wire logic        transactions_outstanding_in,
	input  wire logic [3:0]  err_detect_in,
	output logic             function_reset_trigger_out,
	output logic      [2:0]  read_request_size_limit_out,
	output logic      [12:0] read_request_bytes_out,
	output logic             no_snoop_enable_out,
	output logic             aux_power_pm_enable_out,
	output logic             extended_tag_enable_out,
	output logic      [2:0]  payload_size_limit_out,
	output logic             relaxed_ordering_enable_out,
	output logic      [3:0]  err_report_en_out
);

	// ==========================================
	// Helper functions

	// Byte enables widen to a bit mask for one 16-bit half
	function automatic logic [15:0] pdcs_be_mask(input logic [1:0] be);
		pdcs_be_mask = {{8{be[1]}}, {8{be[0]}}};
	endfunction

	// Reserved size codes clamp to the top size
	// Software must not write them, but a stray code must never ask for more
	function automatic logic [2:0] pdcs_rrs_clamp(input logic [2:0] code);
		if (code > PDCS_RRS_MAX) begin
			pdcs_rrs_clamp = PDCS_RRS_MAX;
		end else begin
			pdcs_rrs_clamp = code;
		end
	endfunction

	// ==========================================
	// State

	logic [15:0] ctrl;
	logic        appm;
	logic [3:0]  err_seen;
	logic        transactions_outstanding;
	logic        aux_meta;
	logic        aux_sync;
	logic        frt_pulse;
	logic [2:0]  rrs_code;
	logic [12:0] rrs_bytes;

	// ==========================================
	// Access decode

	// Control and status share one dword, so one compare serves both halves
	wire         hit        = (cfg_addr_in & PDCS_DWORD_MASK) == PDCS_DEV_CTRL_OFS;
	wire         wr_ctrl    = cfg_wr_in && hit;
	wire         rd_ctrl    = cfg_rd_in && hit;
	wire [15:0]  ctrl_be    = pdcs_be_mask(cfg_be_in[1:0]);
	wire [15:0]  stat_be    = pdcs_be_mask(cfg_be_in[3:2]);
	wire [15:0]  ctrl_wd    = cfg_wdata_in[15:0];
	wire [15:0]  stat_wd    = cfg_wdata_in[31:16];
	wire         wr_hi      = wr_ctrl && cfg_be_in[PDCS_BE_CTRL_HI];

	// ==========================================
	// Control write path

	// Bit 10 lives in its own register, so the common mask leaves it out
	wire [15:0]  wmask      = ctrl_be & PDCS_CTRL_RW & ~PDCS_CTRL_APPM;
	wire [15:0]  next_ctrl  = (ctrl & ~wmask) | (ctrl_wd & wmask);
	wire         next_appm  = ctrl_wd[PDCS_APPM_BIT];
	wire         next_frt   = wr_hi && ctrl_wd[PDCS_FRT_BIT];
	wire [2:0]   next_rrs   = pdcs_rrs_clamp(next_ctrl[PDCS_RRS_HI:PDCS_RRS_LO]);
	wire [12:0]  next_bytes = PDCS_RRS_BASE << next_rrs;

	// ==========================================
	// Status write path

	wire [3:0]   err_clr    = wr_ctrl ? (stat_wd[PDCS_ERR_HI:0] & stat_be[PDCS_ERR_HI:0]) : PDCS_ERR_RESET;
	// set wins over clear
	// An error in the same cycle as its clear must not be lost
	wire [3:0]   next_err   = err_detect_in | (err_seen & ~err_clr);

	// ==========================================
	// Read image

	wire [15:0]  ctrl_rd    = {1'b0, ctrl[PDCS_RRS_HI:PDCS_NS_BIT], appm, 1'b0, ctrl[PDCS_EXTENDED_TAG_ENABLE_BIT:0]};
	wire [15:0]  stat_rd    = {PDCS_STAT_RSVD, transactions_outstanding, aux_sync, err_seen};
	// Unmapped dwords read zero
	wire [31:0]  next_rdata = rd_ctrl ? {stat_rd, ctrl_rd} : PDCS_RDATA_IDLE;

	// ==========================================
	// Control storage

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl <= PDCS_CTRL_RESET & ~PDCS_CTRL_APPM;
		end else if (wr_ctrl) begin
			ctrl <= next_ctrl;
		end
	end

	always_ff @(posedge sys_clk_in or negedge global_rstn_in) begin
		if (!global_rstn_in) begin
			appm <= PDCS_CTRL_RESET[PDCS_APPM_BIT];
		end else if (wr_hi) begin
			appm <= next_appm;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			frt_pulse <= 1'b0;
		end else begin
			frt_pulse <= next_frt;
		end
	end

	// size limit held in flip-flops
	// Loaded from next_ctrl, so they change on the same edge as ctrl and add no lag after a write
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rrs_code  <= PDCS_RRS_RESET;
			rrs_bytes <= PDCS_RRS_RST_B;
		end else if (wr_ctrl) begin
			rrs_code  <= next_rrs;
			rrs_bytes <= next_bytes;
		end
	end

	// ==========================================
	// Status storage

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			err_seen <= PDCS_ERR_RESET;
		end else begin
			err_seen <= next_err;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			transactions_outstanding <= 1'b0;
		end else begin
			transactions_outstanding <= transactions_outstanding_in;
		end
	end

	// aux pin synchroniser
	// The pin is asynchronous to the core clock; only aux_sync is read
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			aux_meta <= 1'b0;
			aux_sync <= 1'b0;
		end else begin
			aux_meta <= aux_power_detect_pin_in;
			aux_sync <= aux_meta;
		end
	end

	// ==========================================
	// Read data

	// Registered so the host sees a clean value one cycle after the strobe
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cfg_rdata_out <= PDCS_RDATA_IDLE;
		end else begin
			cfg_rdata_out <= next_rdata;
		end
	end

	// ==========================================
	// Outputs

	assign function_reset_trigger_out  = frt_pulse;
	assign read_request_size_limit_out = rrs_code;
	assign read_request_bytes_out      = rrs_bytes;
	assign no_snoop_enable_out         = ctrl[PDCS_NS_BIT];
	assign aux_power_pm_enable_out     = appm;
	assign extended_tag_enable_out     = ctrl[PDCS_EXTENDED_TAG_ENABLE_BIT];
	assign payload_size_limit_out      = ctrl[PDCS_MPS_HI:PDCS_MPS_LO];
	assign relaxed_ordering_enable_out = ctrl[PDCS_ERO_BIT];
	assign err_report_en_out           = ctrl[PDCS_ERR_HI:0];

endmodule
`default_nettype wire

// File: sim/pdcs_host.sv
// Host software model issuing configuration accesses.
// Assumes the bench only calls acc and never drives the cfg bus.
`timescale 1ns/1ps
`default_nettype none
module pdcs_host (input wire logic clk, output logic wr, rd, output logic [11:0] a,
	output logic [3:0] be, output logic [31:0] d);
	initial {wr, rd, a, be, d} = '0;
	task automatic acc(input logic w, input logic [11:0] ad, input logic [3:0] b, input logic [31:0] dd);
		@(negedge clk);
		{wr, rd, a, be, d} = {w, !w, ad, b, dd};
		@(negedge clk);
		// Released data is inverted so stale values never look valid
		{wr, rd, d} = {2'h0, ~dd};
	endtask
endmodule
`default_nettype wire

// File: sim/pdcs_regs_chk.sv
// Port assertions for the control/status pair.
// Assumes it is bound onto pdcs_regs.
`timescale 1ns/1ps
`default_nettype none
module pdcs_regs_chk (input wire logic sys_clk_in, rstn_in, cfg_wr_in, cfg_rd_in,
	input wire logic [11:0] cfg_addr_in, input wire logic [3:0] cfg_be_in,
	input wire logic [31:0] cfg_wdata_in, cfg_rdata_out, input wire logic [2:0] read_request_size_limit_out,
	input wire logic function_reset_trigger_out, no_snoop_enable_out, extended_tag_enable_out,
	input wire logic [3:0] err_report_en_out);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	wire hit = (cfg_addr_in & 12'hFFC) == 12'h078;
	wire rh = cfg_rd_in && hit;
	a_frt_pulse: assert property (cfg_wr_in && hit && cfg_be_in[1] && cfg_wdata_in[15]
		|=> function_reset_trigger_out ##1 !function_reset_trigger_out) else $error("bad pulse");
	a_frt_read: assert property (rh |=> !cfg_rdata_out[15]) else $error("bit 15 set");
	a_rrs_legal: assert property (read_request_size_limit_out <= 3'h5) else $error("bad size");
	a_ns_read: assert property (rh |=> cfg_rdata_out[11] == no_snoop_enable_out) else $error("ns");
	a_pfe_zero: assert property (rh |=> !cfg_rdata_out[9]) else $error("bit 9 set");
	a_tag_read: assert property (rh |=> cfg_rdata_out[8] == extended_tag_enable_out) else $error("tag");
	a_rep_read: assert property (rh |=> cfg_rdata_out[3:0] == err_report_en_out) else $error("rep");
	a_rsvd_zero: assert property (cfg_rdata_out[31:22] == 10'h000) else $error("rsvd set");
	c_trig: cover property (function_reset_trigger_out);
	c_read: cover property (rh);
	c_clear: cover property (cfg_wr_in && hit && cfg_be_in[2]);
endmodule
bind pdcs_regs pdcs_regs_chk chk (.*);
`default_nettype wire

// File: sim/pdcs_regs_bench.sv
// Self-checking bench for pdcs_regs.
// Assumes pdcs_host drives the config bus.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin checks++; if ((a)!==(b)) begin n_fail++; $display("[ERR] %0t %h %h",$time,a,b); end end
module pdcs_regs_bench;
	logic clk, rstn, grstn, aux, transactions_outstanding, wr, rd, frt, ns, appm, tag, relaxed_ordering_enable;
	logic [2:0] rrs, payload_size_limit;
	logic [3:0] err, be, ren;
	logic [11:0] a;
	logic [12:0] nb;
	logic [31:0] d, q;
	int n_fail = 0, checks = 0;
	pdcs_host host (.clk(clk), .wr(wr), .rd(rd), .a(a), .be(be), .d(d));
	pdcs_regs uut (.sys_clk_in(clk), .rstn_in(rstn), .global_rstn_in(grstn), .cfg_wr_in(wr), .cfg_rd_in(rd),
		.cfg_addr_in(a), .cfg_be_in(be), .cfg_wdata_in(d), .cfg_rdata_out(q), .aux_power_detect_pin_in(aux),
		.transactions_outstanding_in(transactions_outstanding), .err_detect_in(err), .function_reset_trigger_out(frt),
		.read_request_size_limit_out(rrs), .read_request_bytes_out(nb), .no_snoop_enable_out(ns),
		.aux_power_pm_enable_out(appm), .extended_tag_enable_out(tag), .payload_size_limit_out(payload_size_limit),
		.relaxed_ordering_enable_out(relaxed_ordering_enable), .err_report_en_out(ren));
	initial begin clk = 0; forever #2.5 clk = ~clk; end
	task stop_test;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task t_reset;
		host.acc(0, 12'h078, 4'hF, 0);
		`CHK(q, 32'h0010_2810)
		`CHK(ns, 1'b1)
		`CHK(appm, 1'b0)
		`CHK(nb, 13'h0200)
		$display("t_reset done");
	endtask
	task t_ctrl;
		host.acc(1, 12'h078, 4'h3, 32'hD7FF);
		`CHK(frt, 1'b1)
		@(negedge clk) `CHK(frt, 1'b0)
		host.acc(0, 12'h07A, 4'hF, 0);
		`CHK(q[15:0], 16'h55FF)
		`CHK(nb, 13'h1000)
		`CHK(rrs, 3'h5)
		`CHK(ns, 1'b0)
		`CHK(tag, 1'b1)
		`CHK(payload_size_limit, 3'h7)
		`CHK(relaxed_ordering_enable, 1'b1)
		`CHK(ren, 4'hF)
		$display("t_ctrl done");
	endtask
	task t_stat;
		// Enables off first: detection must not depend on them
		host.acc(1, 12'h078, 4'h3, 0);
		@(negedge clk) {err, transactions_outstanding} = 5'h1F;
		@(negedge clk) err = 4'h0;
		host.acc(1, 12'h078, 4'hC, 32'hFFF5_0000);
		host.acc(0, 12'h078, 4'hF, 0);
		`CHK(q, 32'h003A_0000)
		host.acc(0, 12'h07C, 4'hF, 0);
		`CHK(q, 32'h0)
		$display("t_stat done");
	endtask
	task t_aux;
		aux = 0;
		repeat (3) @(negedge clk);
		host.acc(0, 12'h078, 4'hF, 0);
		`CHK(q[20], 1'b0)
		aux = 1;
		host.acc(1, 12'h078, 4'h3, 32'h0400);
		rstn = 0;
		@(negedge clk) rstn = 1;
		host.acc(0, 12'h078, 4'h3, 0);
		`CHK(q[15:0], 16'h2C10)
		grstn = 0;
		@(negedge clk) grstn = 1;
		`CHK(appm, 1'b0)
		$display("t_aux done");
	endtask
	initial begin
		{rstn, grstn, transactions_outstanding, err, aux} = 8'h01;
		repeat (6) @(negedge clk);
		{rstn, grstn} = 2'h3;
		repeat (3) @(negedge clk);
		t_reset;
		t_ctrl;
		t_stat;
		t_aux;
		stop_test;
	end
	initial begin #5000; n_fail++; stop_test; end
endmodule
`default_nettype wire
